// file: rtl/pwmt_input_filter.sv
`timescale 1ns/1ps
module pwmt_input_filter
   import pwmt_pkg::*;
(
   input wire logic clk,
   input wire logic rstN,
   input wire logic filterEn,
   input wire logic sampleEn,
   input wire logic pinIn,
   output logic level
);

   // ----------------------------------------------------------------
   // Sample history and accepted level
   // ----------------------------------------------------------------
   logic [FILT_LEN-1:0] samples_r;
   logic [FILT_LEN-1:0] samples_nxt;
   logic level_r;
   logic level_nxt;

   // Shift on each sample pulse, accept only a unanimous history
   always_comb begin
      samples_nxt = samples_r;
      level_nxt = level_r;
      if (sampleEn) begin
         samples_nxt = {samples_r[FILT_LEN-2:0], pinIn};
      end
      if (!filterEn) begin
         level_nxt = pinIn;
      end else if (sampleEn && (&samples_nxt)) begin
         level_nxt = 1'b1;
      end else if (sampleEn && !(|samples_nxt)) begin
         level_nxt = 1'b0;
      end
   end

   // Register stage
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         samples_r <= '0;
         level_r <= 1'b0;
      end else begin
         samples_r <= samples_nxt;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;

endmodule : pwmt_input_filter

// file: rtl/pwmt_pkg.sv
package pwmt_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int ST_W = 4;
   localparam int CTRL_W = 8;
   localparam int PRE_W = 5;
   localparam int FILT_LEN = 3;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RELOAD = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_PIN = 8'h1C;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_LEVEL_BIT = 3;
   localparam int CTRL_CLR_BIT = 4;
   localparam int CTRL_FILT_BIT = 5;
   localparam int CTRL_RATE_LSB = 6;

   // ----------------------------------------------------------------
   // Status and interrupt bit positions
   // ----------------------------------------------------------------
   localparam int ST_OVF = 0;
   localparam int ST_UDF = 1;
   localparam int ST_EDGE = 2;
   localparam int ST_END = 3;

   // ----------------------------------------------------------------
   // Values after reset, and the counter step
   // ----------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   localparam logic [CNT_W-1:0] RELOAD_RST = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [ST_W-1:0] ST_RST = 4'h0;

   // ----------------------------------------------------------------
   // Filter sampling divider reset value, step, divide-by-8 mask and terminal counts
   // ----------------------------------------------------------------
   localparam logic [PRE_W-1:0] PRE_RST = 5'h00;
   localparam logic [PRE_W-1:0] PRE_DIV8_TERM = 5'h07;
   localparam logic [PRE_W-1:0] PRE_DIV8_MASK = 5'h07;
   localparam logic [PRE_W-1:0] PRE_DIV32_TERM = 5'h1F;
   localparam logic [PRE_W-1:0] PRE_ONE = 5'h01;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_EDGE_CLEAR = 2'b00,
      MODE_LEVEL_GATED = 2'b01,
      MODE_FREE_CAPTURE = 2'b10
   } pwmt_mode_t;

   typedef enum logic [1:0] {
      RATE_F1 = 2'b00,
      RATE_F8 = 2'b01,
      RATE_F32 = 2'b10,
      RATE_SRC = 2'b11
   } pwmt_rate_t;

endpackage : pwmt_pkg

// file: rtl/pwmt_pulse_timer.sv
// Overview of operation
// - Edge-clear mode: each edge copies count to capture, clears counter, keeps counting up.
// - Edge-clear mode: rising and falling edges both count; no level distinction.
// - Edge-clear mode: event on every effective edge and on counter overflow.
// - Level-gated mode: load reload value, count down only at selected level.
// - Level-gated mode: high or low duration chosen by level selection.
// - Level-gated mode: edge ending selected level raises event and halts counter.
// - Level-gated mode: event on underflow or on completed measurement.
// - Rising-to-falling range measures high period, counting down only while high.
// - Falling-to-rising range measures low period, counting down only while low.
// - Free-capture mode: edge copies count to capture, counter keeps counting up.
// - Free-capture mode: event on each capture and on counter overflow.
// - Clear-on-capture set: counter cleared right after each capture in free-capture mode.
// - Overflow and capture events are separately enabled interrupt sources.
// - Optional filter accepts a level only after three identical samples.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module pwmt_pulse_timer
   import pwmt_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [DATA_W-1:0] rdData,
   input wire logic gatedTimerIoPin,
   output logic irq
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rstSync_r;
   logic [1:0] rstSync_nxt;
   logic rstN;

   // Two-stage release of the asynchronous reset
   always_comb begin
      rstSync_nxt = {rstSync_r[0], 1'b1};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync_r <= 2'b00;
      end else begin
         rstSync_r <= rstSync_nxt;
      end
   end

   assign rstN = rstSync_r[1];

   // ----------------------------------------------------------------
   // Filter sampling divider
   // ----------------------------------------------------------------
   logic [PRE_W-1:0] pre_r;
   logic [PRE_W-1:0] pre_nxt;
   logic [CTRL_W-1:0] ctrl_r;
   logic [CTRL_W-1:0] ctrl_nxt;
   logic sampleEn;
   pwmt_rate_t rateSel;

   // Free-running divider, one-cycle enables for the slower rates
   always_comb begin
      pre_nxt = pre_r + PRE_ONE;
      rateSel = pwmt_rate_t'(ctrl_r[CTRL_RATE_LSB +: 2]);
      unique case (rateSel)
         RATE_F1: sampleEn = 1'b1;
         RATE_F8: sampleEn = ((pre_r & PRE_DIV8_MASK) == PRE_DIV8_TERM);
         RATE_F32: sampleEn = (pre_r == PRE_DIV32_TERM);
         RATE_SRC: sampleEn = 1'b1; // Count source is the clock itself
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pre_r <= PRE_RST;
      end else begin
         pre_r <= pre_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------
   logic pinLevel;

   pwmt_input_filter u_filter (
      .clk(clk),
      .rstN(rstN),
      .filterEn(ctrl_r[CTRL_FILT_BIT]),
      .sampleEn(sampleEn),
      .pinIn(gatedTimerIoPin),
      .level(pinLevel)
   );

   // ----------------------------------------------------------------
   // Core state and registers
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] reload_r;
   logic [CNT_W-1:0] reload_nxt;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] capture_r;
   logic [CNT_W-1:0] capture_nxt;
   logic [ST_W-1:0] status_r;
   logic [ST_W-1:0] status_nxt;
   logic [ST_W-1:0] irqEn_r;
   logic [ST_W-1:0] irqEn_nxt;
   pwmt_mode_t cfgMode_r;
   pwmt_mode_t cfgMode_nxt;
   logic cfgLevel_r;
   logic cfgLevel_nxt;
   logic cfgClr_r;
   logic cfgClr_nxt;
   logic running_r;
   logic running_nxt;
   logic halted_r;
   logic halted_nxt;
   logic prevLevel_r;
   logic prevLevel_nxt;
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] rdData_nxt;

   // Helper terms
   logic run;
   logic start;
   logic edgeAny;
   logic edgeSel;
   logic selLevel;
   logic endEdge;
   logic [CNT_W:0] countInc;
   logic [ST_W-1:0] events;
   logic [ST_W-1:0] clrMask;

   // Next-state computation for counter, capture, flags and bus
   always_comb begin
      ctrl_nxt = ctrl_r;
      reload_nxt = reload_r;
      count_nxt = count_r;
      capture_nxt = capture_r;
      irqEn_nxt = irqEn_r;
      cfgMode_nxt = cfgMode_r;
      cfgLevel_nxt = cfgLevel_r;
      cfgClr_nxt = cfgClr_r;
      halted_nxt = halted_r;
      prevLevel_nxt = pinLevel;
      events = ST_RST;
      clrMask = ST_RST;
      rdData_nxt = '0;

      run = ctrl_r[CTRL_RUN_BIT];
      running_nxt = run;
      start = run && !running_r;
      edgeAny = pinLevel ^ prevLevel_r;
      edgeSel = cfgLevel_r ? (prevLevel_r && !pinLevel) : (!prevLevel_r && pinLevel);
      selLevel = !cfgLevel_r;
      endEdge = (prevLevel_r == selLevel) && (pinLevel != selLevel);
      countInc = {1'b0, count_r} + {1'b0, CNT_ONE};

      // Configuration only follows the control register while stopped
      if (!run) begin
         cfgMode_nxt = pwmt_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
         cfgLevel_nxt = ctrl_r[CTRL_LEVEL_BIT];
         cfgClr_nxt = ctrl_r[CTRL_CLR_BIT];
      end

      // Counting behaviour per active mode
      if (start) begin
         halted_nxt = 1'b0;
         if (cfgMode_r == MODE_LEVEL_GATED) begin
            count_nxt = reload_r;
         end else begin
            count_nxt = CNT_RST;
         end
      end else if (run) begin
         unique case (cfgMode_r)
            MODE_EDGE_CLEAR: begin
               if (edgeAny) begin
                  capture_nxt = count_r;
                  count_nxt = CNT_RST;
                  events[ST_EDGE] = 1'b1;
               end else begin
                  count_nxt = countInc[CNT_W-1:0];
                  events[ST_OVF] = countInc[CNT_W];
               end
            end
            MODE_LEVEL_GATED: begin
               if (!halted_r) begin
                  if (endEdge) begin
                     capture_nxt = count_r;
                     halted_nxt = 1'b1;
                     events[ST_END] = 1'b1;
                  end else if (pinLevel == selLevel) begin
                     // High while rising-to-falling, low otherwise
                     if (count_r == CNT_RST) begin
                        count_nxt = reload_r;
                        events[ST_UDF] = 1'b1;
                     end else begin
                        count_nxt = count_r - CNT_ONE;
                     end
                  end
               end
            end
            MODE_FREE_CAPTURE: begin
               if (edgeSel) begin
                  capture_nxt = count_r;
                  events[ST_EDGE] = 1'b1;
               end
               if (edgeSel && cfgClr_r) begin
                  count_nxt = CNT_RST;
               end else begin
                  count_nxt = countInc[CNT_W-1:0];
                  events[ST_OVF] = countInc[CNT_W];
               end
            end
            default: begin
               count_nxt = count_r; // Unused mode code holds the counter
            end
         endcase
      end

      // Register writes
      if (wrStrobe) begin
         unique case (addr)
            ADDR_CTRL: ctrl_nxt = wrData[CTRL_W-1:0];
            ADDR_RELOAD: reload_nxt = wrData[CNT_W-1:0];
            ADDR_IRQ_EN: irqEn_nxt = wrData[ST_W-1:0];
            ADDR_IRQ_CLR: clrMask = wrData[ST_W-1:0];
            default: clrMask = ST_RST;
         endcase
      end

      // Sticky flags, a new event beats a clear in the same cycle
      status_nxt = (status_r & ~clrMask) | events;

      // Read data for the following cycle
      if (rdStrobe) begin
         unique case (addr)
            ADDR_CTRL: rdData_nxt = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
            ADDR_RELOAD: rdData_nxt = {{(DATA_W-CNT_W){1'b0}}, reload_r};
            ADDR_COUNT: rdData_nxt = {{(DATA_W-CNT_W){1'b0}}, count_r};
            ADDR_CAPTURE: rdData_nxt = {{(DATA_W-CNT_W){1'b0}}, capture_r};
            ADDR_STATUS: rdData_nxt = {{(DATA_W-ST_W){1'b0}}, status_r};
            ADDR_IRQ_EN: rdData_nxt = {{(DATA_W-ST_W){1'b0}}, irqEn_r};
            ADDR_PIN: rdData_nxt = {{(DATA_W-2){1'b0}}, halted_r, pinLevel};
            default: rdData_nxt = '0;
         endcase
      end
   end

   // Register stage for core state
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_r <= CTRL_RST;
         reload_r <= RELOAD_RST;
         count_r <= CNT_RST;
         capture_r <= CNT_RST;
         status_r <= ST_RST;
         irqEn_r <= ST_RST;
         cfgMode_r <= MODE_EDGE_CLEAR;
         cfgLevel_r <= 1'b0;
         cfgClr_r <= 1'b0;
         running_r <= 1'b0;
         halted_r <= 1'b0;
         prevLevel_r <= 1'b0;
         rdData_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         reload_r <= reload_nxt;
         count_r <= count_nxt;
         capture_r <= capture_nxt;
         status_r <= status_nxt;
         irqEn_r <= irqEn_nxt;
         cfgMode_r <= cfgMode_nxt;
         cfgLevel_r <= cfgLevel_nxt;
         cfgClr_r <= cfgClr_nxt;
         running_r <= running_nxt;
         halted_r <= halted_nxt;
         prevLevel_r <= prevLevel_nxt;
         rdData_r <= rdData_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Level interrupt from enabled sticky flags
   assign irq = |(status_r & irqEn_r);
   assign rdData = rdData_r;

endmodule : pwmt_pulse_timer

// file: verification/pwmt_pulse_src.sv
`timescale 1ns/1ps
module pwmt_pulse_src
   import pwmt_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic inv,
   input wire logic [CNT_W-1:0] width,
   output logic pin
);
   logic [CNT_W-1:0] left_r = CNT_RST;
   logic [CNT_W-1:0] left_nxt;
   // Cycles left in the active phase
   always_comb begin
      left_nxt = left_r;
      if (go) begin
         left_nxt = width;
      end else if (left_r != CNT_RST) begin
         left_nxt = left_r - CNT_ONE;
      end
   end
   always_ff @(posedge clk) begin
      left_r <= left_nxt;
   end
   // Idle level is inv, active phase its inverse
   assign pin = inv ^ (left_r != CNT_RST);
endmodule : pwmt_pulse_src

// file: verification/pwmt_pulse_timer_props.sv
`timescale 1ns/1ps
module pwmt_props
   import pwmt_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   input wire logic [DATA_W-1:0] rdData,
   input wire logic gatedTimerIoPin,
   input wire logic irq
);
   logic [CNT_W-1:0] relMir_r;
   logic [CNT_W-1:0] relMir_nxt;
   logic [ST_W-1:0] enMir_r;
   logic [ST_W-1:0] enMir_nxt;
   logic [CTRL_W-1:0] ctlMir_r;
   logic [CTRL_W-1:0] ctlMir_nxt;
   // -------------------------------
   // Register mirrors
   // -------------------------------
   // Follow writes to the writable registers
   always_comb begin
      relMir_nxt = relMir_r;
      enMir_nxt = enMir_r;
      ctlMir_nxt = ctlMir_r;
      if (wrStrobe && addr == ADDR_RELOAD) begin
         relMir_nxt = wrData[CNT_W-1:0];
      end
      if (wrStrobe && addr == ADDR_IRQ_EN) begin
         enMir_nxt = wrData[ST_W-1:0];
      end
      if (wrStrobe && addr == ADDR_CTRL) begin
         ctlMir_nxt = wrData[CTRL_W-1:0];
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         relMir_r <= RELOAD_RST;
         enMir_r <= ST_RST;
         ctlMir_r <= CTRL_RST;
      end else begin
         relMir_r <= relMir_nxt;
         enMir_r <= enMir_nxt;
         ctlMir_r <= ctlMir_nxt;
      end
   end
   // -------------------------------
   // Properties
   // -------------------------------
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_rd_idle;
      !rdStrobe |=> rdData == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
   property p_rd_clr;
      rdStrobe && addr == ADDR_IRQ_CLR |=> rdData == 32'h0000_0000;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("clear register read not zero");
   property p_rd_unmap;
      rdStrobe && (addr > ADDR_PIN || addr[1:0] != 2'b00) |=> rdData == 32'h0000_0000;
   endproperty
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
   property p_rd_reload;
      rdStrobe && addr == ADDR_RELOAD |=> rdData == {16'h0000, relMir_r};
   endproperty
   a_rd_reload: assert property (p_rd_reload) else $error("reload readback wrong");
   property p_rd_ctrl;
      rdStrobe && addr == ADDR_CTRL |=> rdData == {24'h00_0000, ctlMir_r};
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
   property p_rd_irqen;
      rdStrobe && addr == ADDR_IRQ_EN |=> rdData == {28'h000_0000, enMir_r};
   endproperty
   a_rd_irqen: assert property (p_rd_irqen) else $error("enable readback wrong");
   property p_irq_masked;
      enMir_r == ST_RST |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt with no source enabled");
   property p_irq_status;
      rdStrobe && addr == ADDR_STATUS |=> (|(rdData[ST_W-1:0] & enMir_r)) == $past(irq);
   endproperty
   a_irq_status: assert property (p_irq_status) else $error("interrupt disagrees with status");
endmodule : pwmt_props

bind pwmt_pulse_timer pwmt_props i_pwmt_props (.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
   .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .gatedTimerIoPin(gatedTimerIoPin), .irq(irq));

// file: verification/pwmt_pulse_timer_test.sv
`timescale 1ns/1ps
module pwmt_pulse_timer_test;
   import pwmt_pkg::*;
   logic clk;
   logic reset_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData;
   logic wrStrobe;
   logic rdStrobe;
   logic [DATA_W-1:0] rdData;
   logic pin;
   logic irq;
   logic go;
   logic inv;
   logic [CNT_W-1:0] width;
   logic [DATA_W-1:0] rv;
   int errors;
   int checks;
   pwmt_pulse_timer i_pwmt_pulse_timer (.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .gatedTimerIoPin(pin), .irq(irq));
   pwmt_pulse_src i_pwmt_pulse_src (.clk(clk), .go(go), .inv(inv), .width(width), .pin(pin));
   // -------------------------------
   // Bus and check helpers
   // -------------------------------
   task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask : wr
   task automatic rc(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 rv = rdData;
      chk(n, e, rv);
   endtask : rc
   task automatic irqchk(input logic e);
      #1 chk("irq", DATA_W'(e), DATA_W'(irq));
   endtask : irqchk
   task automatic start(input logic [CTRL_W-1:0] cfg);
      wr(ADDR_CTRL, DATA_W'(cfg));
      @(posedge clk);
      wr(ADDR_IRQ_CLR, 32'h0000_000F);
      repeat (4) @(posedge clk);
      wr(ADDR_CTRL, DATA_W'(cfg | 8'h01));
   endtask : start
   task automatic pulse(input logic [CNT_W-1:0] w);
      width <= w;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (w + 16) @(posedge clk);
   endtask : pulse
   // -------------------------------
   // Scenarios
   // -------------------------------
   task automatic t_reset();
      rc("ctrl", ADDR_CTRL, 32'h0000_0000);
      rc("reload", ADDR_RELOAD, 32'h0000_FFFF);
      rc("capture", ADDR_CAPTURE, 32'h0000_0000);
      rc("status", ADDR_STATUS, 32'h0000_0000);
      rc("irq enable", ADDR_IRQ_EN, 32'h0000_0000);
      wr(ADDR_COUNT, 32'h0000_1234);
      rc("count", ADDR_COUNT, 32'h0000_0000);
      rc("unmapped", 8'h20, 32'h0000_0000);
      rc("clear reg", ADDR_IRQ_CLR, 32'h0000_0000);
      start(8'h06);
      repeat (4) @(posedge clk);
      rc("hold count", ADDR_COUNT, 32'h0000_0000);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_edge();
      start(8'h00);
      @(posedge clk);
      wr(ADDR_CTRL, 32'h0000_0005);
      pulse(16'h0019);
      rc("edge capture", ADDR_CAPTURE, 32'h0000_0018);
      rc("edge status", ADDR_STATUS, 32'h0000_0004);
      wr(ADDR_IRQ_EN, 32'h0000_0004);
      irqchk(1'b1);
      wr(ADDR_IRQ_CLR, 32'h0000_000F);
      repeat (65600) @(posedge clk);
      rc("overflow status", ADDR_STATUS, 32'h0000_0001);
      irqchk(1'b0);
      wr(ADDR_IRQ_EN, 32'h0000_0001);
      irqchk(1'b1);
      wr(ADDR_IRQ_EN, 32'h0000_0000);
      $display("t_edge done");
   endtask : t_edge
   task automatic t_level(input logic s, input logic [CNT_W-1:0] w, input logic [CNT_W-1:0] rl,
         input logic [CNT_W-1:0] cap, input logic [ST_W-1:0] stm);
      inv <= s;
      wr(ADDR_RELOAD, DATA_W'(rl));
      repeat (4) @(posedge clk);
      start({4'h0, s, 3'b010});
      pulse(w);
      rc("level status", ADDR_STATUS, DATA_W'(stm));
      chk("status bits", DATA_W'(stm), rv & DATA_W'(stm));
      rc("level pin", ADDR_PIN, DATA_W'({1'b1, s}));
      if (!stm[ST_UDF]) begin
         rc("level capture", ADDR_CAPTURE, DATA_W'(cap));
         rc("level count", ADDR_COUNT, DATA_W'(cap));
      end
      $display("t_level done");
   endtask : t_level
   task automatic t_free();
      inv <= 1'b0;
      start(8'h14);
      pulse(16'h000A);
      pulse(16'h000A);
      rc("clear capture", ADDR_CAPTURE, 32'h0000_001A);
      rc("capture status", ADDR_STATUS, 32'h0000_0004);
      wr(ADDR_IRQ_EN, 32'h0000_0001);
      irqchk(1'b0);
      wr(ADDR_IRQ_EN, 32'h0000_0004);
      irqchk(1'b1);
      wr(ADDR_IRQ_CLR, 32'h0000_0004);
      irqchk(1'b0);
      start(8'h04);
      pulse(16'h000A);
      pulse(16'h000A);
      rc("free capture", ADDR_CAPTURE, 32'h0000_001C);
      chk("not cleared", 32'h0000_0001, DATA_W'(rv > 32'h0000_001A));
      $display("t_free done");
   endtask : t_free
   task automatic t_filter();
      start(8'h20);
      pulse(16'h0002);
      rc("glitch status", ADDR_STATUS, 32'h0000_0000);
      pulse(16'h0006);
      rc("filter status", ADDR_STATUS, 32'h0000_0004);
      rc("filter capture", ADDR_CAPTURE, 32'h0000_0005);
      start(8'h60);
      pulse(16'h0006);
      rc("slow glitch status", ADDR_STATUS, 32'h0000_0000);
      pulse(16'h0028);
      rc("slow filter status", ADDR_STATUS, 32'h0000_0004);
      $display("t_filter done");
   endtask : t_filter
   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   // Clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Main sequence
   initial begin
      reset_n = 1'b0;
      addr = '0;
      wrData = '0;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      go = 1'b0;
      inv = 1'b0;
      width = '0;
      errors = 0;
      checks = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_edge();
      t_level(1'b0, 16'h0032, 16'h03E8, 16'h03B6, 4'h8);
      t_level(1'b1, 16'h0028, 16'h03E8, 16'h03C0, 4'h8);
      t_level(1'b0, 16'h0046, 16'h001E, 16'h0000, 4'hA);
      t_free();
      t_filter();
      test_done();
   end
   // Watchdog
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      test_done();
   end
endmodule : pwmt_pulse_timer_test
